// ===== fe_switch_ctrl.sv
// front-end switch control: registers, lead timing and enable lines
`timescale 1ns/100ps
module fe_switch_ctrl
    import fe_switch_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic tx_request,
    input wire logic rx_active,
    output logic tx_go,
    output logic radio_aux_out_three,
    output logic radio_aux_out_four
);
    // everything the block keeps between edges
    typedef struct packed {
        logic [7:0] transceiver_control_one;   // holds the amp enable bit
        logic [7:0] rf_control_zero;           // holds the lead-time code
        fe_state_t state;                      // where the switching sequence stands
        logic [LEAD_WIDTH-1:0] lead_cnt;       // warm-up cycles still to wait
        logic front_end_transmit_enable;       // registered so the pin never glitches
        logic front_end_receive_enable;        // registered so the pin never glitches
        logic tx_go;                           // modulator release
    } ctrl_state_t;

    ctrl_state_t cur;
    ctrl_state_t next_cur;

    logic [5:0] reg_addr;   // address of the current serial transfer
    logic [7:0] reg_wdata;  // byte to store
    logic reg_write;        // one-cycle store strobe
    logic [7:0] reg_rdata;  // byte shifted out on reads
    logic external_amp_enable_bit;          // gates both front-end lines
    logic [1:0] amp_lead_time_field;        // picks the warm-up span

    // serial access to the register file
    fe_serial_port u_port (
        .clock(clock),
        .arst_n(arst_n),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_rdata(reg_rdata)
    );

    // fields that steer the switching
    assign external_amp_enable_bit = cur.transceiver_control_one[EXTERNAL_AMP_ENABLE_POS];
    assign amp_lead_time_field = cur.rf_control_zero[AMP_LEAD_TIME_LSB +: 2];

    // read mux; unmapped addresses read zero
    always_comb
    begin
        reg_rdata = 8'h00;
        unique case (reg_addr)
            TRANSCEIVER_CONTROL_ONE_OFFSET: reg_rdata = cur.transceiver_control_one;
            RF_CONTROL_ZERO_OFFSET: reg_rdata = cur.rf_control_zero;
            FE_STATUS_OFFSET:
            begin
                // live view of the switching state and both lines
                reg_rdata[STATUS_STATE_LSB +: 2] = cur.state;
                reg_rdata[STATUS_TX_LINE_POS] = cur.front_end_transmit_enable;
                reg_rdata[STATUS_RX_LINE_POS] = cur.front_end_receive_enable;
            end
            default: reg_rdata = 8'h00;
        endcase
    end

    // next-state logic for registers and the switching sequence
    always_comb
    begin
        next_cur = cur;
        // register stores; writes elsewhere are ignored
        if (reg_write)
        begin
            if (reg_addr == TRANSCEIVER_CONTROL_ONE_OFFSET)
            begin
                // [RULE4] host sets or clears the amp enable
                next_cur.transceiver_control_one = reg_wdata;
            end
            else if (reg_addr == RF_CONTROL_ZERO_OFFSET)
            begin
                // [RULE5] lead-time code taken from host
                next_cur.rf_control_zero = reg_wdata;
            end
        end
        unique case (cur.state)
            FE_IDLE:
            begin
                if (tx_request && external_amp_enable_bit)
                begin
                    // [RULE5] amplifier powers up ahead of the burst
                    next_cur.state = FE_LEAD;
                    next_cur.lead_cnt = lead_cycles(amp_lead_time_field);
                end
                else if (tx_request)
                begin
                    // no external amp: send at once, lines stay low
                    next_cur.state = FE_TX;
                end
                else if (rx_active)
                begin
                    next_cur.state = FE_RX;
                end
            end
            FE_LEAD:
            begin
                // a dropped request abandons the warm-up
                if (!tx_request)
                begin
                    next_cur.state = FE_IDLE;
                end
                else if (cur.lead_cnt <= LEAD_WIDTH'(1))
                begin
                    next_cur.state = FE_TX;
                end
                else
                begin
                    next_cur.lead_cnt = cur.lead_cnt - LEAD_WIDTH'(1);
                end
            end
            FE_TX:
            begin
                if (!tx_request)
                begin
                    next_cur.state = FE_IDLE;
                end
            end
            FE_RX:
            begin
                // transmit request preempts reception
                if (!rx_active || tx_request)
                begin
                    next_cur.state = FE_IDLE;
                end
            end
        endcase
        // modulator runs only once warm-up is over
        next_cur.tx_go = (next_cur.state == FE_TX);
        // [RULE2] transmit line high through warm-up and burst
        next_cur.front_end_transmit_enable = external_amp_enable_bit
            && ((next_cur.state == FE_LEAD) || (next_cur.state == FE_TX));
        // [RULE3] receive line high only while receiving
        next_cur.front_end_receive_enable = external_amp_enable_bit
            && (next_cur.state == FE_RX);
        // [RULE9] disabled or idle leaves both lines low
        if (!external_amp_enable_bit || (next_cur.state == FE_IDLE))
        begin
            next_cur.front_end_transmit_enable = 1'b0;
            next_cur.front_end_receive_enable = 1'b0;
        end
    end

    // single state register; reset gives idle with lines low
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur.transceiver_control_one <= TRANSCEIVER_CONTROL_ONE_RESET;
            cur.rf_control_zero <= RF_CONTROL_ZERO_RESET;
            cur.state <= FE_IDLE;
            cur.lead_cnt <= '0;
            cur.front_end_transmit_enable <= 1'b0;
            cur.front_end_receive_enable <= 1'b0;
            cur.tx_go <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // [RULE1] aux pin three carries transmit, four receive
    assign radio_aux_out_three = cur.front_end_transmit_enable;
    assign radio_aux_out_four = cur.front_end_receive_enable;
    assign tx_go = cur.tx_go;
endmodule : fe_switch_ctrl

// ===== fe_switch_pkg.sv
// constants and types for the front-end switch control block
// Behaviour
// [RULE1] aux output three transmits, four receives
// [RULE2] transmitting: transmit line high, receive low
// [RULE3] receiving: transmit line low, receive high
// [RULE4] switching only while amp enable bit set
// [RULE5] lead-time field three selects 8 us
// [RULE6] host clears amp enable before sleep
// [RULE7] host sets amp enable again after wake
// [RULE8] host reaches registers over serial port
// [RULE9] idle or disabled: both lines low
package fe_switch_pkg;
    // register offsets on the serial port
    localparam logic [5:0] TRANSCEIVER_CONTROL_ONE_OFFSET = 6'h04;
    localparam logic [5:0] RF_CONTROL_ZERO_OFFSET = 6'h16;
    localparam logic [5:0] FE_STATUS_OFFSET = 6'h01;
    // field positions
    localparam int EXTERNAL_AMP_ENABLE_POS = 7;
    localparam int AMP_LEAD_TIME_LSB = 0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_TX_LINE_POS = 2;
    localparam int STATUS_RX_LINE_POS = 3;
    // reset values
    localparam logic [7:0] TRANSCEIVER_CONTROL_ONE_RESET = 8'h00;
    localparam logic [7:0] RF_CONTROL_ZERO_RESET = 8'h00;
    // serial command byte layout: write flag, one unused bit, then six address bits
    localparam int CMD_WRITE_POS = 7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // lead time per field code, microseconds, and the clock rate
    localparam int CLOCK_MHZ = 125;
    localparam int LEAD_US_0 = 2;
    localparam int LEAD_US_1 = 4;
    localparam int LEAD_US_2 = 6;
    localparam int LEAD_US_3 = 8;
    localparam int LEAD_WIDTH = 10;
    localparam logic [LEAD_WIDTH-1:0] LEAD_CYCLES_0 = LEAD_WIDTH'(LEAD_US_0 * CLOCK_MHZ);
    localparam logic [LEAD_WIDTH-1:0] LEAD_CYCLES_1 = LEAD_WIDTH'(LEAD_US_1 * CLOCK_MHZ);
    localparam logic [LEAD_WIDTH-1:0] LEAD_CYCLES_2 = LEAD_WIDTH'(LEAD_US_2 * CLOCK_MHZ);
    localparam logic [LEAD_WIDTH-1:0] LEAD_CYCLES_3 = LEAD_WIDTH'(LEAD_US_3 * CLOCK_MHZ);

    // front-end states, gray along idle, lead, transmit
    typedef enum logic [1:0] {
        FE_IDLE = 2'b00,
        FE_LEAD = 2'b01,
        FE_TX = 2'b11,
        FE_RX = 2'b10
    } fe_state_t;

    // lead-time code to cycle count
    function automatic logic [LEAD_WIDTH-1:0] lead_cycles(input logic [1:0] code);
        logic [LEAD_WIDTH-1:0] cycles;
        unique case (code)
            2'h0: cycles = LEAD_CYCLES_0;
            2'h1: cycles = LEAD_CYCLES_1;
            2'h2: cycles = LEAD_CYCLES_2;
            2'h3: cycles = LEAD_CYCLES_3;
        endcase
        return cycles;
    endfunction : lead_cycles
endpackage : fe_switch_pkg

// ===== fe_serial_port.sv
// serial register port: byte framing, write strobe and read shift-out
`timescale 1ns/100ps
module fe_serial_port
    import fe_switch_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    input wire logic [7:0] reg_rdata
);
    // whole port state in one word
    typedef struct packed {
        logic sclk_q;         // last sampled serial clock
        logic [3:0] bit_cnt;  // bits taken in the current byte
        logic [6:0] shift;    // bits of the byte so far
        logic in_data;        // command byte already taken
        logic is_write;       // current transfer writes
        logic load_read;      // fetch read data next cycle
        logic [7:0] out_shift;// read data waiting to go out
        logic miso;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic write;
    } port_state_t;

    port_state_t cur;
    port_state_t next_cur;

    // framing and shifting, mode 0, msb first
    always_comb
    begin
        next_cur = cur;
        next_cur.sclk_q = spi_sclk;
        next_cur.write = 1'b0;
        next_cur.load_read = 1'b0;
        if (cur.load_read)
        begin
            // address settled last cycle, so the mux output is valid now
            next_cur.out_shift = reg_rdata;
        end
        if (spi_cs_n)
        begin
            // deselect ends any transfer, partial bytes are dropped
            next_cur.bit_cnt = 4'h0;
            next_cur.in_data = 1'b0;
            next_cur.miso = 1'b0;
        end
        else if (spi_sclk && !cur.sclk_q)
        begin
            // rising edge: take one bit
            next_cur.shift = {cur.shift[5:0], spi_mosi};
            next_cur.bit_cnt = cur.bit_cnt + 4'h1;
            if (cur.bit_cnt == BITS_PER_BYTE - 4'h1)
            begin
                next_cur.bit_cnt = 4'h0;
                if (!cur.in_data)
                begin
                    // [RULE8] command byte decode
                    next_cur.in_data = 1'b1;
                    next_cur.is_write = cur.shift[CMD_WRITE_POS-1];
                    next_cur.addr = {cur.shift[4:0], spi_mosi};
                    next_cur.load_read = 1'b1;
                end
                else if (cur.is_write)
                begin
                    // [RULE8] data byte strobed into register
                    next_cur.wdata = {cur.shift, spi_mosi};
                    next_cur.write = 1'b1;
                end
            end
        end
        else if (!spi_sclk && cur.sclk_q && cur.in_data && !cur.is_write)
        begin
            // falling edge in a read: present next bit
            next_cur.miso = cur.out_shift[7];
            next_cur.out_shift = {cur.out_shift[6:0], 1'b0};
        end
    end

    // state register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign spi_miso = cur.miso;
    assign reg_addr = cur.addr;
    assign reg_wdata = cur.wdata;
    assign reg_write = cur.write;
endmodule : fe_serial_port

// ===== fe_switch_ctrl_asserts.sv
// port assertions for the front-end switch control block
`timescale 1ns/100ps
module fe_switch_checker
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic tx_request,
    input wire logic rx_active,
    input wire logic tx_go,
    input wire logic radio_aux_out_three,
    input wire logic radio_aux_out_four
);
    // cycles with the transmit line up while sending is still held back
    logic [10:0] lead_count;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // restarts whenever lead is left, so only one unbroken lead is measured
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            lead_count <= 11'h000;
        else if (radio_aux_out_three && !tx_go)
            lead_count <= lead_count + 11'h001;
        else
            lead_count <= 11'h000;
    end
    property p_excl; !(radio_aux_out_three && radio_aux_out_four); endproperty
    a_excl: assert property (p_excl) else $error("both lines high");
    property p_tx_cause; radio_aux_out_three |-> $past(tx_request); endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("tx line uncaused");
    property p_rx_cause; radio_aux_out_four |-> $past(rx_active) && !$past(tx_request); endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("rx line uncaused");
    property p_tx_drop; !tx_request |=> !tx_go && !radio_aux_out_three; endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("tx not dropped");
    property p_rx_drop; !rx_active |=> !radio_aux_out_four; endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx not dropped");
    property p_lead_first; $rose(radio_aux_out_three) |-> !tx_go; endproperty
    a_lead_first: assert property (p_lead_first) else $error("no lead");
    property p_lead_span;
        $rose(tx_go) && radio_aux_out_three |-> lead_count inside {11'h0FA, 11'h1F4, 11'h2EE, 11'h3E8};
    endproperty
    a_lead_span: assert property (p_lead_span) else $error("lead span wrong");
    property p_go_cause; tx_go |-> $past(tx_request); endproperty
    a_go_cause: assert property (p_go_cause) else $error("send uncaused");
    property p_miso_idle; spi_cs_n [*2] |-> !spi_miso; endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("miso driven idle");
    // main scenarios: lead then send, receive, enable dropped mid-send
    cover property ($rose(tx_go) && radio_aux_out_three);
    cover property ($rose(radio_aux_out_four));
    cover property ($fell(radio_aux_out_three) && tx_go);
endmodule : fe_switch_checker

bind fe_switch_ctrl fe_switch_checker checker_inst (.*);

// ===== fe_amp_model.sv
// behavioural external front end: amplifier warms up, receive path follows at once
`timescale 1ns/100ps
module fe_amp_model #(
    parameter int SETTLE = 200
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic tx_enable_line,
    input wire logic rx_enable_line,
    output logic amp_ready,
    output logic lna_on
);
    // cycles the amplifier has been powered; saturates to avoid wrap
    int warm;
    // bias needs time, which is why the lead must cover the settle span
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            warm <= 0;
        else if (tx_enable_line)
            warm <= (warm < SETTLE) ? warm + 1 : warm;
        else
            warm <= 0;
    end
    assign amp_ready = (warm >= SETTLE);
    assign lna_on = rx_enable_line && !tx_enable_line;
endmodule : fe_amp_model

// ===== tb_top.sv
// self-checking testbench for the front-end switch control block
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic spi_sclk = 1'b0;
    logic spi_cs_n = 1'b1;
    logic spi_mosi = 1'b0;
    logic tx_request = 1'b0;
    logic rx_active = 1'b0;
    logic spi_miso, tx_go, radio_aux_out_three, radio_aux_out_four, amp_ready, lna_on;
    int fail_count = 0;
    int samples_checked = 0;
    // enable, tx, rx, then expected transmit line, receive line, send
    logic [5:0] rows [6] = '{6'h35, 6'h2A, 6'h3D, 6'h20, 6'h11, 6'h08};
    logic [10:0] n;

    fe_switch_ctrl dut (.*);
    // slow amplifier, settling just inside the shortest lead
    fe_amp_model #(.SETTLE(240)) front_end (.clock(clock), .arst_n(arst_n),
        .tx_enable_line(radio_aux_out_three), .rx_enable_line(radio_aux_out_four),
        .amp_ready(amp_ready), .lna_on(lna_on));

    initial forever #4 clock = ~clock;

    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // one select: command then data, sclk held low three clocks and high two clocks per bit
    task automatic spi(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, dat};
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_mosi = sh[i];
            repeat (3) @(negedge clock);
            if (i < 8)
                rd[i] = spi_miso;
            spi_sclk = 1'b1;
            repeat (2) @(negedge clock);
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge clock);
        spi_cs_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask : spi

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi({2'b10, a}, d, x);
    endtask : wr

    task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] x;
        spi({2'b00, a}, 8'h00, x);
        check(what, 11'(e), 11'(x));
    endtask : rd_chk

    task automatic final_report();
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // watchdog, well beyond the roughly 11300 cycles of the sequence
    initial
    begin
        repeat (60000) @(posedge clock);
        fail_count++;
        final_report();
    end

    initial
    begin
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        @(negedge clock);
        wr(6'h16, 8'h03);
        for (int r = 0; r < 6; r++)
        begin
            wr(6'h04, {rows[r][5], 7'h00});
            {tx_request, rx_active} = rows[r][4:3];
            repeat (1010) @(negedge clock);
            check("lines", 11'(rows[r][2:0]), 11'({radio_aux_out_three,
                radio_aux_out_four, tx_go}));
            check("lna", 11'(rows[r][1]), 11'(lna_on));
            {tx_request, rx_active} = 2'b00;
            repeat (2) @(negedge clock);
        end
        // last row left the amp enable clear; every lead needs it set
        wr(6'h04, 8'h80);
        // every lead code, measured edge by edge
        for (int c = 0; c < 4; c++)
        begin
            wr(6'h16, 8'(c));
            rd_chk("lead code", 6'h16, 8'(c));
            tx_request = 1'b1;
            n = 11'h000;
            do
            begin
                @(negedge clock);
                n++;
            end while (tx_go !== 1'b1 && n < 11'h7D0);
            check("lead", 11'h0FA * 11'(c + 1) + 11'h001, n);
            check("amp ready", 11'h001, 11'(amp_ready));
            tx_request = 1'b0;
            repeat (2) @(negedge clock);
        end
        // enable withdrawn mid-send, then restored after the burst
        wr(6'h16, 8'h00);
        tx_request = 1'b1;
        repeat (260) @(negedge clock);
        wr(6'h04, 8'h00);
        check("sleep", 11'h001, 11'({radio_aux_out_three, tx_go}));
        tx_request = 1'b0;
        repeat (2) @(negedge clock);
        wr(6'h04, 8'h80);
        tx_request = 1'b1;
        repeat (260) @(negedge clock);
        check("wake", 11'h003, 11'({radio_aux_out_three, tx_go}));
        // reset in mid-send clears lines and registers
        arst_n = 1'b0;
        @(negedge clock);
        check("reset", 11'h000, 11'({radio_aux_out_three, radio_aux_out_four, tx_go}));
        arst_n = 1'b1;
        @(negedge clock);
        rd_chk("ctrl reset", 6'h04, 8'h00);
        rd_chk("rf reset", 6'h16, 8'h00);
        // status is read-only, unmapped space reads zero
        wr(6'h01, 8'hFF);
        rd_chk("status", 6'h01, 8'h03);
        wr(6'h3F, 8'hA5);
        rd_chk("unmapped", 6'h3F, 8'h00);
        final_report();
    end
endmodule : tb_top
